// >>> plg_pkg.sv
/*
  Constants for the partition label generator: exception levels, field
  widths, register layout positions and system-register encodings.
  Assumes the core supplies its current level and security state.
*/
// What this block does
// - Same labels at Secure and Non-secure levels
// - Secure state drives partition space low
// - Non-secure state drives partition space high
// - Labels come from current level's register
// - Translation also applies in Secure state
// - Never qualifier high with address-space low
// - Cross-state Secure label, Non-secure address allowed
// - Virtualization needs EL2 and supported flag
// - Trap EL1 id register reads when enabled
// - Separate map enables for app, guest
// - Up to eight map registers, EL2 writable
// - Virtual id indexes entry and valid bit
// - Out-of-range virtual id gets in-range replacement
// - Invalid entry falls to default, then physical
// - Host-in-EL2 redirects guest encoding to hypervisor
// - Alias encodings undefined at EL1 and EL0
// - Locked EL0 uses guest register; EL2/EL3 untranslated
// - Map register holds four 16-bit physical ids
// - One valid bit per implemented virtual id
package plg_pkg;
  // Exception levels
  localparam logic [1:0] EL0 = 2'h0;
  localparam logic [1:0] EL1 = 2'h1;
  localparam logic [1:0] EL2 = 2'h2;
  localparam logic [1:0] EL3 = 2'h3;
  // Field widths
  localparam int PID_W   = 16;
  localparam int PMG_W   = 8;
  localparam int MAPS    = 8;
  localparam int ENT_PER = 4;
  localparam int VID_W   = 5;
  // Label register layout: instruction id, data id, instr group, data group
  localparam int LBL_W   = 48;
  localparam int LBL_PI  = 0;
  localparam int LBL_PD  = 16;
  localparam int LBL_GI  = 32;
  localparam int LBL_GD  = 40;
  // Default virtual and physical partition ids
  localparam logic [4:0]  DEF_VID = 5'h00;
  localparam logic [15:0] DEF_PID = 16'h0000;
  // Register select codes
  localparam logic [3:0] SEL_APP   = 4'h0;
  localparam logic [3:0] SEL_GUEST = 4'h1;
  localparam logic [3:0] SEL_HYP   = 4'h2;
  localparam logic [3:0] SEL_MON   = 4'h3;
  localparam logic [3:0] SEL_VCTL  = 4'h4;
  localparam logic [3:0] SEL_VALID = 4'h5;
  localparam logic [3:0] SEL_MAP   = 4'h6;
  localparam logic [3:0] SEL_ID    = 4'h7;
  localparam logic [3:0] SEL_ALIAS = 4'h8;
  // Encoding fields of the guest label register
  localparam logic [2:0] ENC_OP1_EL1   = 3'h0;
  localparam logic [2:0] ENC_OP1_ALIAS = 3'h5;
  localparam logic [3:0] ENC_CRN       = 4'hA;
  localparam logic [3:0] ENC_CRM       = 4'h5;
  localparam logic [2:0] ENC_OP2       = 3'h0;
  // Virtualization control bit positions
  localparam int VC_APP_EN  = 0;
  localparam int VC_GST_EN  = 1;
  localparam int VC_LOCK    = 8;
  localparam int VC_IDTRAP  = 31;
  // Map register count minus one, reported by the id register
  localparam logic [2:0] MAP_CNT_MAX = 3'h7;
  // Virtualization support built in, reported in the id register
  localparam logic       VIRT_OK_HW  = 1'b1;
endpackage : plg_pkg

// >>> plg_vmap.sv
/*
  Virtual-to-physical partition id mapper: entry array and valid bits.
  Assumes the caller qualifies the result with its own enable.
*/
`timescale 1ns/1ps
module plg_vmap #(
  parameter int PID_W = 16,           // Physical id width
  parameter int VID_W = 5             // Virtual id width
) (
  input  wire logic [VID_W-1:0]  vid,         // Virtual id
  input  wire logic [2:0]        cnt_max,     // Map register count minus one
  input  wire logic [4*PID_W*8-1:0] entries,  // All map entries
  input  wire logic [31:0]       valid,       // Valid bits
  output logic      [PID_W-1:0]  pid          // Physical id
);
  // Highest in-range virtual id, four per register plus three
  wire [VID_W-1:0] top_vid = {cnt_max, 2'b11};
  // Out-of-range ids fold onto the default entry
  wire [VID_W-1:0] eff_vid = (vid > top_vid) ? plg_pkg::DEF_VID : vid;
  wire             hit     = valid[eff_vid];
  wire             def_ok  = valid[plg_pkg::DEF_VID];
  wire [PID_W-1:0] e_pid   = entries[eff_vid*PID_W +: PID_W];
  wire [PID_W-1:0] d_pid   = entries[plg_pkg::DEF_VID*PID_W +: PID_W];
  // Indexed, then default entry, then default physical id
  assign pid = hit ? e_pid : (def_ok ? d_pid : plg_pkg::DEF_PID);
endmodule : plg_vmap

// >>> plg_top.sv
/*
  Partition label generator: holds label, control, map and valid
  registers, serves system-register accesses and labels each request.
  Assumes the core gives level, security state and request strobe.
*/
`timescale 1ns/1ps
module plg_top #(
  parameter int MAPS = plg_pkg::MAPS  // Implemented map registers
) (
  input  wire logic        CORE_CLK,     // 20 MHz clock
  input  wire logic        RST,          // Sync reset, high
  input  wire logic [1:0]  CUR_EL,       // Current exception level
  input  wire logic        CUR_NS,       // Current state non-secure
  input  wire logic        EL2_EN,       // EL2 enabled in this state
  input  wire logic        HOST_IN_EL2,  // Host-in-EL2 flag
  input  wire logic        REQ_VALID,    // Memory request strobe
  input  wire logic        REQ_INSTR,    // Instruction access
  input  wire logic        REQ_ADDR_NS,  // Requested address space
  input  wire logic        SR_VALID,     // System register access
  input  wire logic        SR_WRITE,     // Write when high
  input  wire logic [2:0]  SR_OP1,       // Encoding op1
  input  wire logic [3:0]  SR_CRN,       // Encoding CRn
  input  wire logic [3:0]  SR_CRM,       // Encoding CRm
  input  wire logic [2:0]  SR_OP2,       // Encoding op2
  input  wire logic [3:0]  SR_SEL,       // Decoded register select
  input  wire logic [2:0]  SR_IDX,       // Map register index
  input  wire logic [63:0] SR_WDATA,     // Write data
  output logic [63:0]      SR_RDATA,     // Read data
  output logic             SR_UNDEF,     // Undefined instruction
  output logic             SR_TRAP_EL2,  // Trap to EL2
  output logic             OUT_VALID,    // Labelled request valid
  output logic [15:0]      OUT_PID,      // partition_id
  output logic [7:0]       OUT_PMG,      // perf_monitor_group
  output logic             OUT_PNS,      // partition_space_nonsecure
  output logic             OUT_ANS       // address_space_nonsecure
);
  localparam int PW = plg_pkg::PID_W;
  localparam int LW = plg_pkg::LBL_W;
  // Label registers per level
  logic [LW-1:0]   app_ff, guest_ff, hyp_ff, mon_ff;
  logic [31:0]     vctl_ff;         // Virtualization control
  logic [31:0]     valid_ff;        // Map valid bits
  logic [4*PW-1:0] map_ff [8];      // Map registers
  logic [4*PW*8-1:0] map_flat;      // Flattened map entries
  // Output holding registers
  logic            o_valid_ff, o_pns_ff, o_ans_ff, undef_ff, trap_ff;
  logic [15:0]     o_pid_ff;
  logic [7:0]      o_pmg_ff;
  logic [63:0]     rdata_ff;

  // Flatten map registers, unimplemented ones read as zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flat
      assign map_flat[gi*4*PW +: 4*PW] = (gi < MAPS) ? map_ff[gi] : '0;
    end
  endgenerate

  // Virtualization offered only with EL2 on and support flag set
  wire virt_ok   = EL2_EN & plg_pkg::VIRT_OK_HW;
  wire lock      = vctl_ff[plg_pkg::VC_LOCK];
  wire app_en    = vctl_ff[plg_pkg::VC_APP_EN];
  wire gst_en    = vctl_ff[plg_pkg::VC_GST_EN];
  // Label register selection by level, same in both security states
  wire use_guest = (CUR_EL == plg_pkg::EL1) | ((CUR_EL == plg_pkg::EL0) & lock);
  wire [LW-1:0] sel_lbl = (CUR_EL == plg_pkg::EL3) ? mon_ff :
                          (CUR_EL == plg_pkg::EL2) ? hyp_ff :
                          use_guest ? guest_ff : app_ff;
  // Translation never at EL2 or EL3
  wire do_map = virt_ok & ~CUR_EL[1] & (use_guest ? gst_en : app_en);
  wire [PW-1:0] raw_pid = REQ_INSTR ? sel_lbl[plg_pkg::LBL_PI +: PW]
                                    : sel_lbl[plg_pkg::LBL_PD +: PW];
  wire [7:0]    raw_pmg = REQ_INSTR ? sel_lbl[plg_pkg::LBL_GI +: 8]
                                    : sel_lbl[plg_pkg::LBL_GD +: 8];
  wire [PW-1:0] map_pid;
  // Mapper lookup on the low virtual id bits
  plg_vmap #(.PID_W(PW), .VID_W(plg_pkg::VID_W)) u_vmap (
    .vid     (raw_pid[plg_pkg::VID_W-1:0]),
    .cnt_max (plg_pkg::MAP_CNT_MAX),
    .entries (map_flat),
    .valid   (valid_ff),
    .pid     (map_pid)
  );
  wire [PW-1:0] fin_pid = do_map ? map_pid : raw_pid;
  // Non-secure state cannot reach Secure addresses
  wire addr_ns = REQ_ADDR_NS | CUR_NS;

  // Encoding decode for aliasing
  wire enc_base  = (SR_CRN == plg_pkg::ENC_CRN) & (SR_CRM == plg_pkg::ENC_CRM)
                 & (SR_OP2 == plg_pkg::ENC_OP2);
  wire is_guest  = enc_base & (SR_OP1 == plg_pkg::ENC_OP1_EL1);
  wire is_alias  = (SR_SEL == plg_pkg::SEL_ALIAS);
  wire redirect  = HOST_IN_EL2 & (CUR_EL == plg_pkg::EL2) & is_guest;
  wire low_el    = ~CUR_EL[1];
  wire sr_undef  = SR_VALID & is_alias & low_el;
  wire sr_trap   = SR_VALID & ~SR_WRITE & (SR_SEL == plg_pkg::SEL_ID)
                 & (CUR_EL == plg_pkg::EL1) & vctl_ff[plg_pkg::VC_IDTRAP] & virt_ok;
  wire sr_ok     = SR_VALID & ~sr_undef & ~sr_trap;
  wire el2_up    = CUR_EL[1];
  // Effective target after aliasing; alias reaches guest register
  wire [3:0] eff_sel = redirect ? plg_pkg::SEL_HYP :
                       is_alias ? plg_pkg::SEL_GUEST : SR_SEL;
  wire wr = sr_ok & SR_WRITE;
  // Hypervisor-only registers need EL2 or above
  wire wr_app   = wr & (eff_sel == plg_pkg::SEL_APP);
  wire wr_guest = wr & (eff_sel == plg_pkg::SEL_GUEST);
  wire wr_hyp   = wr & (eff_sel == plg_pkg::SEL_HYP) & el2_up;
  wire wr_mon   = wr & (eff_sel == plg_pkg::SEL_MON) & (CUR_EL == plg_pkg::EL3);
  wire wr_vctl  = wr & (eff_sel == plg_pkg::SEL_VCTL) & el2_up;
  wire wr_valid = wr & (eff_sel == plg_pkg::SEL_VALID) & el2_up;
  wire wr_map   = wr & (eff_sel == plg_pkg::SEL_MAP) & el2_up & (32'(SR_IDX) < MAPS);
  // Read mux
  logic [63:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    case (eff_sel)
      plg_pkg::SEL_APP:   rd_mux = 64'(app_ff);
      plg_pkg::SEL_GUEST: rd_mux = 64'(guest_ff);
      plg_pkg::SEL_HYP:   rd_mux = 64'(hyp_ff);
      plg_pkg::SEL_MON:   rd_mux = 64'(mon_ff);
      plg_pkg::SEL_VCTL:  rd_mux = 64'(vctl_ff);
      plg_pkg::SEL_VALID: rd_mux = 64'(valid_ff);
      plg_pkg::SEL_MAP:   rd_mux = map_flat[SR_IDX*4*PW +: 4*PW];
      plg_pkg::SEL_ID:    rd_mux = {59'h0, plg_pkg::MAP_CNT_MAX, 2'h0} | 64'(plg_pkg::VIRT_OK_HW);
      default:            rd_mux = '0;
    endcase
  end

  // Register writes
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      app_ff   <= '0;
      guest_ff <= '0;
      hyp_ff   <= '0;
      mon_ff   <= '0;
      vctl_ff  <= '0;
      valid_ff <= '0;
    end
    else
    begin
      if (wr_app)   app_ff   <= SR_WDATA[LW-1:0];
      if (wr_guest) guest_ff <= SR_WDATA[LW-1:0];
      if (wr_hyp)   hyp_ff   <= SR_WDATA[LW-1:0];
      if (wr_mon)   mon_ff   <= SR_WDATA[LW-1:0];
      if (wr_vctl)  vctl_ff  <= SR_WDATA[31:0];
      if (wr_valid) valid_ff <= SR_WDATA[31:0] & {{(32-4*8){1'b0}}, {(4*8){1'b1}}};
    end
  end

  // Map register array
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
      for (int i = 0; i < 8; i++) map_ff[i] <= '0;
    else if (wr_map)
      map_ff[SR_IDX] <= SR_WDATA;
  end

  // Registered request labels, one per accepted request
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      o_valid_ff <= 1'b0;
      o_pid_ff   <= '0;
      o_pmg_ff   <= '0;
      o_pns_ff   <= 1'b0;
      o_ans_ff   <= 1'b0;
    end
    else
    begin
      o_valid_ff <= REQ_VALID;
      if (REQ_VALID)
      begin
        o_pid_ff <= fin_pid;
        o_pmg_ff <= raw_pmg;
        o_pns_ff <= CUR_NS;
        o_ans_ff <= addr_ns;
      end
    end
  end

  // Access answer
  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      undef_ff <= 1'b0;
      trap_ff  <= 1'b0;
      rdata_ff <= '0;
    end
    else
    begin
      undef_ff <= sr_undef;
      trap_ff  <= sr_trap;
      rdata_ff <= (sr_ok & ~SR_WRITE) ? rd_mux : '0;
    end
  end

  assign OUT_VALID   = o_valid_ff;
  assign OUT_PID     = o_pid_ff;
  assign OUT_PMG     = o_pmg_ff;
  assign OUT_PNS     = o_pns_ff;
  assign OUT_ANS     = o_ans_ff;
  assign SR_RDATA    = rdata_ff;
  assign SR_UNDEF    = undef_ff;
  assign SR_TRAP_EL2 = trap_ff;

  // Checks
  a_pns_secure: assert property (@(posedge CORE_CLK) disable iff (RST)
    REQ_VALID & ~CUR_NS |=> ~OUT_PNS) else $error("secure request not low");
  a_pns_nonsec: assert property (@(posedge CORE_CLK) disable iff (RST)
    REQ_VALID & CUR_NS |=> OUT_PNS) else $error("nonsecure request not high");
  a_no_illegal: assert property (@(posedge CORE_CLK) disable iff (RST)
    OUT_VALID |-> !(OUT_PNS & ~OUT_ANS)) else $error("illegal space pairing");
  a_cross_kept: assert property (@(posedge CORE_CLK) disable iff (RST)
    REQ_VALID & ~CUR_NS & REQ_ADDR_NS |=> OUT_ANS & ~OUT_PNS) else $error("cross lost");
  a_hyp_untrans: assert property (@(posedge CORE_CLK) disable iff (RST)
    REQ_VALID & (CUR_EL == plg_pkg::EL2) & ~REQ_INSTR
    |=> OUT_PID == $past(hyp_ff[plg_pkg::LBL_PD +: 16])) else $error("hyp label mapped");
  a_alias_undef: assert property (@(posedge CORE_CLK) disable iff (RST)
    SR_VALID & (SR_SEL == plg_pkg::SEL_ALIAS) & ~CUR_EL[1] |=> SR_UNDEF) else $error("alias allowed");
  a_id_trap: assert property (@(posedge CORE_CLK) disable iff (RST)
    SR_TRAP_EL2 |-> $past(CUR_EL) == plg_pkg::EL1) else $error("trap wrong level");
  a_redirect: assert property (@(posedge CORE_CLK) disable iff (RST)
    SR_VALID & SR_WRITE & redirect & ~is_alias |=> hyp_ff == $past(SR_WDATA[LW-1:0])) else $error("no redirect");
  a_flat_map: assert property (@(posedge CORE_CLK) disable iff (RST)
    REQ_VALID & ~do_map |=> OUT_PID == $past(raw_pid)) else $error("unmapped changed");
  a_same_lbl: assert property (@(posedge CORE_CLK) disable iff (RST)
    REQ_VALID |=> OUT_PMG == $past(raw_pmg)) else $error("group differs");
endmodule : plg_top

// >>> plg_msc_model.sv
/*
  Memory-system component model: takes every labelled request and
  counts arrivals and illegal label and address-space pairings.
  Assumes it watches the generator's registered outputs on one clock.
*/
`timescale 1ns/1ps
module plg_msc_model (
  input  wire logic        clk,        // Core clock
  input  wire logic        rst,        // Sync reset, high
  input  wire logic        req_valid,  // Labelled request pulse
  input  wire logic        part_ns,    // Partition space qualifier
  input  wire logic        addr_ns,    // Address space bit
  output logic      [15:0] rx_cnt,     // Requests taken
  output logic      [15:0] bad_cnt     // Illegal pairings seen
);
  // Accept each pulse; flag a non-secure label aimed at secure space
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_cnt  <= 16'h0000;
      bad_cnt <= 16'h0000;
    end
    else if (req_valid)
    begin
      rx_cnt  <= rx_cnt + 16'h0001;
      bad_cnt <= bad_cnt + {15'h0000, part_ns & ~addr_ns};
    end
  end
endmodule : plg_msc_model

// >>> plg_top_test.sv
/*
  Self-checking bench for the partition label generator: random labels,
  maps and levels with alias, trap and permission corner cases.
  Assumes plg_pkg, plg_top and plg_msc_model are compiled before it.
*/
`timescale 1ns/1ps
module plg_top_test;
  logic        CORE_CLK = 1'b0;              // Clock
  logic        RST = 1'b1;                   // Reset
  logic [1:0]  CUR_EL = 2'h0;                // Level
  logic        CUR_NS = 1'b0, EL2_EN = 1'b0; // State
  logic        HOST_IN_EL2 = 1'b0;           // Host flag
  logic        REQ_VALID = 1'b0, REQ_INSTR = 1'b0, REQ_ADDR_NS = 1'b0; // Request
  logic        SR_VALID = 1'b0, SR_WRITE = 1'b0;                       // Access
  logic [2:0]  SR_OP1 = 3'h0, SR_OP2 = 3'h0, SR_IDX = 3'h0;            // Encoding
  logic [3:0]  SR_CRN = 4'h0, SR_CRM = 4'h0, SR_SEL = 4'h0;            // Encoding
  logic [63:0] SR_WDATA = 64'h0000_0000_0000_0000;                     // Write data
  logic [63:0] SR_RDATA;                     // Read data
  logic        SR_UNDEF, SR_TRAP_EL2, OUT_VALID, OUT_PNS, OUT_ANS;     // Flags
  logic [15:0] OUT_PID, rx_cnt, bad_cnt;     // Labels, model counts
  logic [7:0]  OUT_PMG;                      // Monitor group
  logic [47:0] lbl [4];                      // Shadow app, guest, hyp, monitor
  logic [63:0] vmap [8];                     // Shadow map registers
  logic [31:0] vld = 32'h0000_0000, vctl = 32'h0000_0000; // Shadow valid, control
  logic [15:0] last_pid, sent = 16'h0000;    // Last label, requests sent
  integer      seed = 32'h1cc4;              // Random seed
  int          fail_count = 0, total_checks = 0, i, n;

  plg_top dut_u (.CORE_CLK(CORE_CLK), .RST(RST), .CUR_EL(CUR_EL), .CUR_NS(CUR_NS),
    .EL2_EN(EL2_EN), .HOST_IN_EL2(HOST_IN_EL2), .REQ_VALID(REQ_VALID),
    .REQ_INSTR(REQ_INSTR), .REQ_ADDR_NS(REQ_ADDR_NS), .SR_VALID(SR_VALID),
    .SR_WRITE(SR_WRITE), .SR_OP1(SR_OP1), .SR_CRN(SR_CRN), .SR_CRM(SR_CRM),
    .SR_OP2(SR_OP2), .SR_SEL(SR_SEL), .SR_IDX(SR_IDX), .SR_WDATA(SR_WDATA),
    .SR_RDATA(SR_RDATA), .SR_UNDEF(SR_UNDEF), .SR_TRAP_EL2(SR_TRAP_EL2),
    .OUT_VALID(OUT_VALID), .OUT_PID(OUT_PID), .OUT_PMG(OUT_PMG), .OUT_PNS(OUT_PNS),
    .OUT_ANS(OUT_ANS));
  plg_msc_model msc_u (.clk(CORE_CLK), .rst(RST), .req_valid(OUT_VALID),
    .part_ns(OUT_PNS), .addr_ns(OUT_ANS), .rx_cnt(rx_cnt), .bad_cnt(bad_cnt));

  // Compare one value, report and count a mismatch
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Print the counts and the verdict, then stop
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Random label: small ids so some fall out of the virtual range
  function automatic logic [47:0] rnd_lbl;
    logic [31:0] t;
    t = $random(seed);
    return {t[31:16], 10'h000, t[5:0], 10'h000, t[13:8]};
  endfunction : rnd_lbl

  // Drop both strobes for one cycle
  task automatic idle;
    SR_VALID  = 1'b0;
    REQ_VALID = 1'b0;
    @(negedge CORE_CLK);
  endtask : idle

  // One system-register access, answer checked a cycle later
  task automatic sr(input logic wr, input logic [3:0] sel, input logic [2:0] idx,
                    input logic [63:0] wd);
    logic [3:0] eff;
    logic       und, trp, g;
    g   = (sel == plg_pkg::SEL_GUEST) || (sel == plg_pkg::SEL_ALIAS);
    und = (sel == plg_pkg::SEL_ALIAS) && (CUR_EL < plg_pkg::EL2);
    trp = !wr && sel == plg_pkg::SEL_ID && CUR_EL == plg_pkg::EL1 && vctl[31] && EL2_EN;
    eff = (sel == plg_pkg::SEL_ALIAS) ? plg_pkg::SEL_GUEST : sel;
    if (sel == plg_pkg::SEL_GUEST && CUR_EL == plg_pkg::EL2 && HOST_IN_EL2)
      eff = plg_pkg::SEL_HYP;
    SR_VALID = 1'b1;
    SR_WRITE = wr;
    SR_SEL   = sel;
    SR_IDX   = idx;
    SR_WDATA = wd;
    SR_OP1   = (sel == plg_pkg::SEL_ALIAS) ? plg_pkg::ENC_OP1_ALIAS : plg_pkg::ENC_OP1_EL1;
    SR_CRN   = g ? plg_pkg::ENC_CRN : 4'h0;
    SR_CRM   = g ? plg_pkg::ENC_CRM : 4'h0;
    SR_OP2   = plg_pkg::ENC_OP2;
    @(negedge CORE_CLK);
    chk(SR_UNDEF, und);
    chk(SR_TRAP_EL2, trp);
    if (!wr && eff < 4'h4)
      chk(SR_RDATA[47:0], lbl[eff[1:0]]);
    if (!wr && eff == plg_pkg::SEL_MAP)
      chk(SR_RDATA, vmap[idx]);
    if (!wr && sel == plg_pkg::SEL_ID && !trp)
      chk({SR_RDATA[4:2], SR_RDATA[0]}, {plg_pkg::MAP_CNT_MAX, 1'b1});
    if (wr && !und)
      case (eff)
        4'h0, 4'h1: if (CUR_EL >= plg_pkg::EL1) lbl[eff[1:0]] = wd[47:0];
        4'h2: if (CUR_EL >= plg_pkg::EL2) lbl[2] = wd[47:0];
        4'h3: if (CUR_EL == plg_pkg::EL3) lbl[3] = wd[47:0];
        4'h4: if (CUR_EL >= plg_pkg::EL2) vctl = wd[31:0];
        4'h5: if (CUR_EL >= plg_pkg::EL2) vld = wd[31:0];
        4'h6: if (CUR_EL >= plg_pkg::EL2) vmap[idx] = wd;
        default: ;
      endcase
  endtask : sr

  // One memory request, labels checked a cycle later
  task automatic req(input logic [1:0] el, input logic ns, ins, ans, e2);
    logic [47:0] r;
    logic [15:0] v, p;
    logic [4:0]  x;
    logic        en, app;
    CUR_EL      = el;
    CUR_NS      = ns;
    EL2_EN      = e2;
    REQ_VALID   = 1'b1;
    REQ_INSTR   = ins;
    REQ_ADDR_NS = ans;
    app = (el == plg_pkg::EL0) && !vctl[plg_pkg::VC_LOCK];
    r   = app ? lbl[0] : (el < plg_pkg::EL2) ? lbl[1] : lbl[el];
    en  = e2 && el < plg_pkg::EL2 && (app ? vctl[0] : vctl[1]);
    v   = ins ? r[15:0] : r[31:16];
    x   = v[4:0];  // wide ids truncate onto the low bits
    p   = !en ? v : vld[x] ? vmap[x[4:2]][{x[1:0], 4'h0} +: 16]
        : vld[plg_pkg::DEF_VID] ? vmap[0][15:0] : plg_pkg::DEF_PID;
    sent++;
    last_pid = p;
    @(negedge CORE_CLK);
    chk(OUT_VALID, 1'b1);
    chk(OUT_PID, p);
    chk(OUT_PMG, ins ? r[39:32] : r[47:40]);
    chk(OUT_PNS, ns);
    chk(OUT_ANS, ans | ns);
  endtask : req

  initial
  begin
    forever #25 CORE_CLK = ~CORE_CLK;
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    fail_count++;
    final_report();
  end

  // Main sequence
  initial
  begin
    for (i = 0; i < 4; i++) lbl[i] = 48'h0000_0000_0000;
    for (i = 0; i < 8; i++) vmap[i] = 64'h0000_0000_0000_0000;
    repeat (3) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RST = 1'b0;
    chk({OUT_VALID, OUT_PID, SR_UNDEF}, 18'h0_0000);
    CUR_EL = plg_pkg::EL3;
    for (i = 0; i < 4; i++) sr(1'b1, i[3:0], 3'h0, {16'h0000, rnd_lbl()});
    for (i = 0; i < 8; i++) sr(1'b1, plg_pkg::SEL_MAP, i[2:0], {$random(seed), $random(seed)});
    sr(1'b1, plg_pkg::SEL_ALIAS, 3'h0, {16'h0000, rnd_lbl()});
    idle();
    sr(1'b0, plg_pkg::SEL_GUEST, 3'h0, 64'h0000_0000_0000_0000);
    sr(1'b0, plg_pkg::SEL_MAP, 3'h5, 64'h0000_0000_0000_0000);
    CUR_EL = plg_pkg::EL1;
    for (i = 2; i < 9; i++) sr(1'b1, i[3:0], 3'h1, 64'hFFFF_FFFF_FFFF_FFFF);
    CUR_EL = plg_pkg::EL2;
    HOST_IN_EL2 = 1'b1;
    sr(1'b1, plg_pkg::SEL_GUEST, 3'h0, {16'h0000, rnd_lbl()});
    sr(1'b1, plg_pkg::SEL_ALIAS, 3'h0, {16'h0000, rnd_lbl()});
    idle();
    HOST_IN_EL2 = 1'b0;
    sr(1'b0, plg_pkg::SEL_HYP, 3'h0, 64'h0000_0000_0000_0000);
    sr(1'b0, plg_pkg::SEL_GUEST, 3'h0, 64'h0000_0000_0000_0000);
    EL2_EN = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      CUR_EL = plg_pkg::EL2;
      sr(1'b1, plg_pkg::SEL_VCTL, 3'h0, {32'h0000_0000, i[0], 31'h0000_0003});
      CUR_EL = plg_pkg::EL1;
      sr(1'b0, plg_pkg::SEL_ID, 3'h0, 64'h0000_0000_0000_0000);
    end
    for (n = 0; n < 400; n++)
    begin
      if (n % 20 == 0)
      begin
        idle();
        CUR_EL = plg_pkg::EL2;
        sr(1'b1, plg_pkg::SEL_VCTL, 3'h0, {32'h0000_0000, $random(seed)});
        sr(1'b1, plg_pkg::SEL_VALID, 3'h0, {32'h0000_0000, $random(seed)});
        for (i = 0; i < 3; i++) sr(1'b1, i[3:0], 3'h0, {16'h0000, rnd_lbl()});
        sr(1'b1, plg_pkg::SEL_MAP, n[4:2], {$random(seed), $random(seed)});
        idle();
      end
      i = $random(seed);
      req(i[1:0], i[2], i[3], i[4], i[5] | i[6]);
    end
    idle();
    chk({OUT_VALID, OUT_PID}, {1'b0, last_pid});
    chk({rx_cnt, bad_cnt}, {sent, 16'h0000});
    final_report();
  end
endmodule : plg_top_test
